// ### inc/drive_status_map.vh
// Purpose: constants of the drive status output selector
// Assumes: frequencies in 0.01 Hz units, dc link in whole volts
// Notes:   byte offsets on a 32-bit AXI4-Lite register bus
`ifndef DRIVE_STATUS_MAP_VH
`define DRIVE_STATUS_MAP_VH

// ***************************************************
// register offsets
// ***************************************************
`define OFS_SELECT    8'h00
`define OFS_MASK      8'h04
`define OFS_LEVEL     8'h08
`define OFS_BANDWIDTH 8'h0c
`define OFS_MAXFREQ   8'h10
`define OFS_CONFIG    8'h14
`define OFS_STATUS    8'h18

// ***************************************************
// field positions
// ***************************************************
`define SEL_TERM_LSB  0
`define SEL_RELAY_LSB 8
`define CFG_FAN_MODE  0
`define CFG_BRAKE_EN  1
`define CFG_HI_CLASS  2
`define CFG_TRIES_LSB 8
`define ST_TERM_BIT   20
`define ST_RELAY_BIT  21

// ***************************************************
// reset values and limits
// ***************************************************
`define RST_TERM_SEL  5'h0c
`define RST_RELAY_SEL 5'h11
`define RST_MASK      3'h2
`define RST_LEVEL     16'h0bb8
`define RST_BANDWIDTH 16'h03e8
`define FREQ_CEILING  16'h9c40
`define CODE_LAST     5'h13
`define OV_LOW_CLASS  10'h190
`define OV_HIGH_CLASS 10'h334
`define UV_LOW_CLASS  10'h0b4
`define UV_HIGH_CLASS 10'h168
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`endif

// ### rtl/drive_status_output_selector.v
// Purpose: picks the drive condition shown on the terminal and relay
// Assumes: all drive core inputs are on aclk, no synchroniser needed
// Notes:   rejected writes answer SLVERR and leave the register alone
`timescale 1ns/1ps
`include "drive_status_map.vh"

module drive_status_output_selector #(
  parameter [15:0] MAX_FREQ_DEFAULT = 16'h1770
) (
  // clock, reset, enable
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        ce,
  // axi4-lite write address and data
  input  wire [7:0]  awaddr,
  input  wire        awvalid,
  output reg         awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output reg         wready,
  // axi4-lite write response
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  // axi4-lite read
  input  wire [7:0]  araddr,
  input  wire        arvalid,
  output reg         arready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready,
  // frequencies and dc link voltage from the drive core
  input  wire [15:0] preset_freq,
  input  wire [15:0] output_freq,
  input  wire [15:0] run_freq,
  input  wire [9:0]  dc_link_volts,
  // status flags from the drive core
  input  wire        accelerating,
  input  wire        decelerating,
  input  wire        motor_overload_warning,
  input  wire        drive_overload_warning,
  input  wire        motor_stall,
  input  wire        overvoltage_trip,
  input  wire        undervoltage_trip,
  input  wire        other_trip,
  input  wire        heatsink_overtemp_trip,
  input  wire        analog_cmd_lost,
  input  wire        serial_cmd_lost,
  input  wire        run_cmd,
  input  wire        voltage_out,
  input  wire        speed_search,
  input  wire        wait_run_cmd,
  input  wire        fan_trip,
  input  wire        brake_signal,
  // selected outputs
  output reg         open_collector_output,
  output reg         relay_contact_output
);

  // ***************************************************
  // helpers
  // ***************************************************

  // absolute difference of two frequencies
  function [15:0] abs_diff;
    input [15:0] a;
    input [15:0] b;
    begin
      abs_diff = (a > b) ? a - b : b - a;
    end
  endfunction

  // one condition out of the vector by code
  function pick;
    input [4:0]  code;
    input [19:0] conds;
    begin
      pick = (code <= `CODE_LAST) ? conds[code] : 1'b0;
    end
  endfunction

  // byte-lane merge of a write into a register word
  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i])
          merge[i*8 +: 8] = data[i*8 +: 8];
      end
    end
  endfunction

  // ***************************************************
  // registers
  // ***************************************************
  reg [4:0]  terminal_source_select;
  reg [4:0]  relay_source_select;
  reg [2:0]  fault_class_mask;
  reg [15:0] freq_detect_level;
  reg [15:0] freq_detect_bandwidth;
  reg [15:0] max_frequency_limit;
  reg        fan_trip_mode;
  reg        brake_enable;
  reg        high_voltage_class;
  reg [7:0]  auto_restart_tries;
  reg        hyst_state;
  reg [7:0]  waddr_q;
  reg [31:0] wdata_q;
  reg [3:0]  wstrb_q;

  // ***************************************************
  // condition logic
  // ***************************************************
  wire [15:0] half_bw = {1'b0, freq_detect_bandwidth[15:1]};
  wire [16:0] low_edge = {1'b0, freq_detect_level} - {1'b0, half_bw};
  wire        speed_match_detect;
  wire        level_match_detect;
  wire        level_window_detect;
  wire        level_hysteresis_detect;
  wire        level_hysteresis_inverted;
  wire        ov_cond;
  wire        uv_cond;
  wire        fault_cond;
  wire [19:0] conds;
  reg         next_hyst;

  // frequency comparisons
  assign speed_match_detect =
    abs_diff(preset_freq, output_freq) <= half_bw;
  assign level_match_detect = (preset_freq == freq_detect_level)
    && speed_match_detect;
  assign level_window_detect =
    abs_diff(freq_detect_level, run_freq) <= half_bw;
  assign level_hysteresis_detect = hyst_state;
  assign level_hysteresis_inverted = ~hyst_state;

  // set on reaching level, hold until at or below level minus half band
  always @* begin
    if (hyst_state)
      next_hyst = low_edge[16] || ({1'b0, run_freq} > low_edge);
    else
      next_hyst = run_freq >= freq_detect_level;
  end

  // dc link thresholds back up the trip flag of the protection logic
  assign ov_cond = overvoltage_trip || (high_voltage_class ?
    dc_link_volts > `OV_HIGH_CLASS : dc_link_volts > `OV_LOW_CLASS);
  assign uv_cond = undervoltage_trip || (high_voltage_class ?
    dc_link_volts < `UV_HIGH_CLASS : dc_link_volts < `UV_LOW_CLASS);

  // restart tries set: only bit 2 lets the fault through
  assign fault_cond = ((fault_class_mask[0] && uv_cond) ||
    (fault_class_mask[1] && other_trip)) &&
    ((auto_restart_tries == 8'h00) || fault_class_mask[2]);

  // condition vector, bit index equals code
  assign conds = {
    brake_enable && brake_signal,
    fan_trip && !fan_trip_mode,
    fault_cond,
    wait_run_cmd,
    speed_search,
    voltage_out && !accelerating && !decelerating,
    !run_cmd && !voltage_out,
    run_cmd && voltage_out,
    analog_cmd_lost || serial_cmd_lost,
    heatsink_overtemp_trip,
    uv_cond,
    ov_cond,
    motor_stall,
    drive_overload_warning,
    motor_overload_warning,
    level_hysteresis_inverted,
    level_hysteresis_detect,
    level_window_detect,
    level_match_detect,
    speed_match_detect
  };

  // ***************************************************
  // output registers
  // ***************************************************

  // registered so a glitch in the core never reaches a relay coil
  always @(posedge aclk) begin
    if (!aresetn) begin
      open_collector_output <= 1'b0;
      relay_contact_output  <= 1'b0;
      hyst_state            <= 1'b0;
    end else if (ce) begin
      open_collector_output <= pick(terminal_source_select, conds);
      relay_contact_output  <= pick(relay_source_select, conds);
      hyst_state            <= next_hyst;
    end
  end

  // ***************************************************
  // register write path
  // ***************************************************
  wire [31:0] old_word =
    (waddr_q == `OFS_SELECT)    ? {19'h0, relay_source_select,
                                   3'h0, terminal_source_select} :
    (waddr_q == `OFS_MASK)      ? {29'h0, fault_class_mask} :
    (waddr_q == `OFS_LEVEL)     ? {16'h0, freq_detect_level} :
    (waddr_q == `OFS_BANDWIDTH) ? {16'h0, freq_detect_bandwidth} :
    (waddr_q == `OFS_MAXFREQ)   ? {16'h0, max_frequency_limit} :
    (waddr_q == `OFS_CONFIG)    ? {16'h0, auto_restart_tries, 5'h0,
                                   high_voltage_class, brake_enable,
                                   fan_trip_mode} : 32'h0;
  wire [31:0] new_word = merge(old_word, wdata_q, wstrb_q);
  wire [4:0]  new_term = new_word[`SEL_TERM_LSB +: 5];
  wire [4:0]  new_relay = new_word[`SEL_RELAY_LSB +: 5];
  wire [15:0] new_freq = new_word[15:0];
  wire        freq_ok = (new_freq <= `FREQ_CEILING) &&
                        (new_freq <= max_frequency_limit);
  wire        do_write = !awready && !wready && !bvalid;

  // both halves latched, then write and answer together
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready                <= 1'b1;
      wready                 <= 1'b1;
      bvalid                 <= 1'b0;
      bresp                  <= `RESP_OKAY;
      waddr_q                <= 8'h00;
      wdata_q                <= 32'h0;
      wstrb_q                <= 4'h0;
      terminal_source_select <= `RST_TERM_SEL;
      relay_source_select    <= `RST_RELAY_SEL;
      fault_class_mask       <= `RST_MASK;
      freq_detect_level      <= `RST_LEVEL;
      freq_detect_bandwidth  <= `RST_BANDWIDTH;
      max_frequency_limit    <= MAX_FREQ_DEFAULT;
      fan_trip_mode          <= 1'b0;
      brake_enable           <= 1'b0;
      high_voltage_class     <= 1'b0;
      auto_restart_tries     <= 8'h00;
    end else if (ce) begin
      if (awvalid && awready) begin
        waddr_q <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        wdata_q <= wdata;
        wstrb_q <= wstrb;
        wready  <= 1'b0;
      end
      if (do_write) begin
        bvalid <= 1'b1;
        bresp  <= `RESP_OKAY;
        case (waddr_q)
          `OFS_SELECT: begin
            // both codes must be legal or nothing changes
            if (new_term <= `CODE_LAST && new_relay <= `CODE_LAST) begin
              terminal_source_select <= new_term;
              relay_source_select    <= new_relay;
            end else
              bresp <= `RESP_SLVERR;
          end
          `OFS_MASK:
            fault_class_mask <= new_word[2:0];
          `OFS_LEVEL: begin
            if (freq_ok)
              freq_detect_level <= new_freq;
            else
              bresp <= `RESP_SLVERR;
          end
          `OFS_BANDWIDTH: begin
            if (freq_ok)
              freq_detect_bandwidth <= new_freq;
            else
              bresp <= `RESP_SLVERR;
          end
          `OFS_MAXFREQ: begin
            if (new_freq <= `FREQ_CEILING)
              max_frequency_limit <= new_freq;
            else
              bresp <= `RESP_SLVERR;
          end
          `OFS_CONFIG: begin
            fan_trip_mode      <= new_word[`CFG_FAN_MODE];
            brake_enable       <= new_word[`CFG_BRAKE_EN];
            high_voltage_class <= new_word[`CFG_HI_CLASS];
            auto_restart_tries <= new_word[`CFG_TRIES_LSB +: 8];
          end
          default:
            bresp <= `RESP_SLVERR; // status is read only
        endcase
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // ***************************************************
  // register read path
  // ***************************************************
  reg [31:0] read_word;
  reg        read_hit;

  // decode of the read address
  always @* begin
    read_word = 32'h0;
    read_hit  = 1'b1;
    case (araddr)
      `OFS_SELECT:
        read_word = {19'h0, relay_source_select, 3'h0,
                     terminal_source_select};
      `OFS_MASK:
        read_word = {29'h0, fault_class_mask};
      `OFS_LEVEL:
        read_word = {16'h0, freq_detect_level};
      `OFS_BANDWIDTH:
        read_word = {16'h0, freq_detect_bandwidth};
      `OFS_MAXFREQ:
        read_word = {16'h0, max_frequency_limit};
      `OFS_CONFIG:
        read_word = {16'h0, auto_restart_tries, 5'h0,
                     high_voltage_class, brake_enable, fan_trip_mode};
      `OFS_STATUS: begin
        read_word = {12'h0, conds};
        read_word[`ST_TERM_BIT]  = open_collector_output;
        read_word[`ST_RELAY_BIT] = relay_contact_output;
      end
      default:
        read_hit = 1'b0;
    endcase
  end

  // one read at a time, answer one cycle after the address
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= `RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= read_word;
        rresp   <= read_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

endmodule // drive_status_output_selector

// ### verification/drive_status_output_selector_bench.sv
// Purpose: directed checks of the drive status output selector
// Assumes: wstrb tied high, one bus transfer at a time
// Notes:   outputs are judged as the wired equipment sees them
`timescale 1ns/1ps
`include "drive_status_map.vh"
module drive_status_output_selector_bench;
  // ***************************************************
  // signals
  // ***************************************************
  logic        aclk = 1'h0, aresetn = 1'h0, ce = 1'h1;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic        arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [15:0] preset_freq = 16'h0, output_freq = 16'h0, run_freq = 16'h0;
  logic [9:0]  dc_link_volts = 10'h12c;
  logic accelerating = 1'h0, decelerating = 1'h0, motor_stall = 1'h0;
  logic motor_overload_warning = 1'h0, drive_overload_warning = 1'h0;
  logic overvoltage_trip = 1'h0, undervoltage_trip = 1'h0;
  logic other_trip = 1'h0, heatsink_overtemp_trip = 1'h0;
  logic analog_cmd_lost = 1'h0, serial_cmd_lost = 1'h0, run_cmd = 1'h0;
  logic voltage_out = 1'h0, speed_search = 1'h0, wait_run_cmd = 1'h0;
  logic fan_trip = 1'h0, brake_signal = 1'h0;
  logic open_collector_output, relay_contact_output, oc_seen, relay_seen;
  int   err_count = 0, total_checks = 0, cyc = 0;

  // 125 MHz
  always #4 aclk = ~aclk;
  drive_status_output_selector DUT (.ce(ce), .wstrb(4'hf), .*);
  output_equipment EQ (.*);

  // ***************************************************
  // tasks
  // ***************************************************
  task automatic chk(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // handshakes judged at the rising edge itself; bready and rready stay
  // high between transfers so no step drops and raises them at once
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] e);
    logic b;
    logic [1:0] r;
    awaddr <= a; wdata <= d; awvalid <= 1'h1; wvalid <= 1'h1;
    bready <= 1'h1; b = 1'h0;
    while (!b) begin
      @(posedge aclk);
      b = bvalid; r = bresp;
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end
    chk("bresp", {30'h0, e}, {30'h0, r});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] e);
    logic v;
    logic [31:0] d;
    logic [1:0] r;
    araddr <= a; arvalid <= 1'h1; rready <= 1'h1; v = 1'h0;
    while (!v) begin
      @(posedge aclk);
      v = rvalid; d = rdata; r = rresp;
      if (arvalid && arready) arvalid <= 1'h0;
    end
    chk("rdata", ed, d);
    chk("rresp", {30'h0, e}, {30'h0, r});
  endtask
  task automatic sel(input logic [4:0] t, r);
    wr(`OFS_SELECT, {19'h0, r, 3'h0, t}, `RESP_OKAY);
  endtask
  // two clocks of selector latency plus one of the equipment
  task automatic obs(input logic et, er);
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    chk("terminal", {31'h0, et}, {31'h0, oc_seen});
    chk("relay", {31'h0, er}, {31'h0, relay_seen});
    @(posedge aclk);
  endtask
  task automatic fq(input logic [4:0] t, r, input logic [15:0] p, o, n,
                    input logic et, er);
    sel(t, r);
    preset_freq <= p; output_freq <= o; run_freq <= n;
    obs(et, er);
  endtask
  // dc link level against both selected outputs
  task automatic dcv(input logic [9:0] v, input logic eo, eu);
    dc_link_volts <= v;
    obs(eo, eu);
  endtask
  task automatic drv(input logic [4:0] c, input logic v);
    case (c)
      5'h05: motor_overload_warning <= v;
      5'h06: drive_overload_warning <= v;
      5'h07: motor_stall <= v;
      5'h08: overvoltage_trip <= v;
      5'h09: undervoltage_trip <= v;
      5'h0a: heatsink_overtemp_trip <= v;
      5'h0b: analog_cmd_lost <= v;
      5'h0c: begin run_cmd <= v; voltage_out <= v; end
      5'h0d: run_cmd <= !v;
      5'h0e: voltage_out <= v;
      5'h0f: speed_search <= v;
      5'h10: wait_run_cmd <= v;
      5'h11: other_trip <= v;
      5'h12: fan_trip <= v;
      default: brake_signal <= v;
    endcase
  endtask

  // ***************************************************
  // scenarios
  // ***************************************************
  task automatic reg_access;
    rd(`OFS_SELECT, 32'h110c, `RESP_OKAY);
    rd(`OFS_MASK, 32'h2, `RESP_OKAY);
    rd(`OFS_LEVEL, 32'hbb8, `RESP_OKAY);
    rd(`OFS_BANDWIDTH, 32'h3e8, `RESP_OKAY);
    rd(`OFS_STATUS, 32'h2011, `RESP_OKAY);
    wr(`OFS_SELECT, 32'h14, `RESP_SLVERR);
    wr(`OFS_STATUS, 32'h0, `RESP_SLVERR);
    wr(`OFS_MAXFREQ, 32'h9c41, `RESP_SLVERR);
    rd(`OFS_SELECT, 32'h110c, `RESP_OKAY);
    wr(`OFS_LEVEL, 32'h1771, `RESP_SLVERR);
    wr(`OFS_BANDWIDTH, 32'h1770, `RESP_OKAY);
    rd(`OFS_BANDWIDTH, 32'h1770, `RESP_OKAY);
    wr(`OFS_BANDWIDTH, 32'h3e8, `RESP_OKAY);
    rd(8'h1c, 32'h0, `RESP_SLVERR);
  endtask
  task automatic freq_detect;
    fq(5'h0, 5'h1, 16'hbb8, 16'hdac, 16'h0, 1'h1, 1'h1);
    fq(5'h0, 5'h1, 16'hbb8, 16'hdad, 16'h0, 1'h0, 1'h0);
    fq(5'h1, 5'h0, 16'hbb9, 16'hbb9, 16'h0, 1'h0, 1'h1);
    fq(5'h2, 5'h2, 16'h0, 16'h0, 16'h9c4, 1'h1, 1'h1);
    fq(5'h2, 5'h2, 16'h0, 16'h0, 16'h9c3, 1'h0, 1'h0);
    fq(5'h3, 5'h4, 16'h0, 16'h0, 16'hbb7, 1'h0, 1'h1);
    fq(5'h3, 5'h4, 16'h0, 16'h0, 16'hbb8, 1'h1, 1'h0);
    fq(5'h3, 5'h4, 16'h0, 16'h0, 16'h9c5, 1'h1, 1'h0);
    fq(5'h3, 5'h4, 16'h0, 16'h0, 16'h9c4, 1'h0, 1'h1);
    run_freq <= 16'h0;
  endtask
  // trip thresholds of both voltage classes, edges included
  task automatic volts;
    sel(5'h08, 5'h09);
    dcv(10'h191, 1'h1, 1'h0);
    dcv(10'h190, 1'h0, 1'h0);
    dcv(10'h0b3, 1'h0, 1'h1);
    dcv(10'h0b4, 1'h0, 1'h0);
    wr(`OFS_CONFIG, 32'h4, `RESP_OKAY);
    dcv(10'h335, 1'h1, 1'h0);
    dcv(10'h334, 1'h0, 1'h0);
    dcv(10'h167, 1'h0, 1'h1);
    dcv(10'h168, 1'h0, 1'h0);
    dc_link_volts <= 10'h12c;
  endtask
  // low enable freezes the outputs, release lets them follow again
  task automatic ce_freeze;
    sel(5'h0b, 5'h0b);
    ce <= 1'h0; analog_cmd_lost <= 1'h1;
    obs(1'h0, 1'h0);
    ce <= 1'h1;
    obs(1'h1, 1'h1);
    analog_cmd_lost <= 1'h0;
  endtask
  task automatic flag_codes;
    wr(`OFS_CONFIG, 32'h2, `RESP_OKAY);
    for (int c = 5; c < 20; c++) begin
      sel(c[4:0], c[4:0]);
      drv(c[4:0], 1'h1);
      obs(1'h1, 1'h1);
      drv(c[4:0], 1'h0);
      obs(1'h0, 1'h0);
    end
    wr(`OFS_CONFIG, 32'h1, `RESP_OKAY);
    sel(5'h12, 5'h13);
    fan_trip <= 1'h1; brake_signal <= 1'h1;
    obs(1'h0, 1'h0);
    fan_trip <= 1'h0; brake_signal <= 1'h0; run_cmd <= 1'h0;
  endtask
  task automatic fault_mask;
    sel(5'h11, 5'h11);
    wr(`OFS_MASK, 32'h1, `RESP_OKAY);
    undervoltage_trip <= 1'h1;
    obs(1'h1, 1'h1);
    undervoltage_trip <= 1'h0; other_trip <= 1'h1;
    obs(1'h0, 1'h0);
    wr(`OFS_MASK, 32'h3, `RESP_OKAY);
    wr(`OFS_CONFIG, 32'h100, `RESP_OKAY);
    obs(1'h0, 1'h0);
    wr(`OFS_MASK, 32'h7, `RESP_OKAY);
    obs(1'h1, 1'h1);
    other_trip <= 1'h0;
  endtask
  task automatic reset_mid;
    sel(5'h0d, 5'h0d);
    obs(1'h1, 1'h1);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk("terminal", 32'h0, {31'h0, oc_seen});
    chk("relay", 32'h0, {31'h0, relay_seen});
    @(posedge aclk);
    aresetn <= 1'h1;
    run_cmd <= 1'h1; voltage_out <= 1'h1; other_trip <= 1'h1;
    obs(1'h1, 1'h1);
    rd(`OFS_SELECT, 32'h110c, `RESP_OKAY);
    run_cmd <= 1'h0; voltage_out <= 1'h0; other_trip <= 1'h0;
  endtask

  // ***************************************************
  // sequence and watchdog
  // ***************************************************
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    reg_access;
    freq_detect;
    volts;
    flag_codes;
    ce_freeze;
    fault_mask;
    reset_mid;
    final_report;
  end
  // a hung handshake would otherwise stall the run forever
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      $display("[ERR] watchdog expected done seen hang");
      final_report;
    end
  end
endmodule // drive_status_output_selector_bench

bind drive_status_output_selector drive_status_props PROPS (.*);

// ### verification/drive_status_props.sv
// Purpose: timing checks of the selector at its ports
// Assumes: ce is held high while these checks run
// Notes:   no_wr marks the stretch before software writes
`timescale 1ns/1ps
module drive_status_props (
  // clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // bus handshakes
  input wire logic       awvalid,
  input wire logic       awready,
  input wire logic       wvalid,
  input wire logic       wready,
  input wire logic       bvalid,
  input wire logic       bready,
  input wire logic       arvalid,
  input wire logic       arready,
  input wire logic       rvalid,
  input wire logic       rready,
  // drive flags and outputs
  input wire logic       run_cmd,
  input wire logic       voltage_out,
  input wire logic       other_trip,
  input wire logic       open_collector_output,
  input wire logic       relay_contact_output
);
  // ***************************************************
  // helper and properties
  // ***************************************************
  logic no_wr;
  // defaults hold only until the first accepted write
  always @(posedge aclk) begin
    if (!aresetn) no_wr <= 1'h1;
    else if (awvalid && awready) no_wr <= 1'h0;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_reset_clears: assert property (disable iff (1'h0) !aresetn |=>
    !open_collector_output && !relay_contact_output)
    else $error("outputs not cleared by reset");
  a_default_term: assert property (no_wr |=>
    open_collector_output == $past(run_cmd && voltage_out))
    else $error("terminal default source wrong");
  a_default_relay: assert property (no_wr |=>
    relay_contact_output == $past(other_trip))
    else $error("relay default source wrong");
  a_write_answer: assert property (awvalid && awready && wvalid && wready
    |=> !bvalid ##1 bvalid) else $error("write answer late");
  a_write_blocks: assert property (bvalid |-> !awready && !wready)
    else $error("write taken during response");
  a_write_release: assert property (bvalid && bready |=>
    !bvalid && awready && wready) else $error("write not released");
  a_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read answer late");
  a_read_release: assert property (rvalid && rready |=> !rvalid && arready)
    else $error("read not released");
  c_write: cover property (bvalid && bready);
  c_read: cover property (rvalid && rready);
  c_term_on: cover property ($rose(open_collector_output));
endmodule // drive_status_props

// ### verification/output_equipment.sv
// Purpose: control equipment wired to the terminal and relay
// Assumes: equipment reads both contacts once per clock
// Notes:   its view lags the selector by one clock
`timescale 1ns/1ps
module output_equipment (
  // clock
  input wire logic  aclk,
  // wired contacts
  input wire logic  open_collector_output,
  input wire logic  relay_contact_output,
  // equipment view
  output logic      oc_seen,
  output logic      relay_seen
);
  // ***************************************************
  // contact sampling
  // ***************************************************
  // latched so a glitch between edges never reaches the bench
  always @(posedge aclk) begin
    oc_seen <= open_collector_output;
    relay_seen <= relay_contact_output;
  end
endmodule // output_equipment
